// ===== accel_fifo_pkg.sv
// constants and types for the acceleration sample queue
`default_nettype none
package accel_fifo_pkg;
   localparam int DEPTH = 32;
   localparam logic [5:0] DEPTH_CNT = 6'h20;
   localparam logic [5:0] REG_DATA_FIRST = 6'h32;
   localparam logic [5:0] REG_DATA_LAST = 6'h37;
   localparam logic [5:0] REG_CTL = 6'h38;
   localparam logic [5:0] REG_STATUS = 6'h39;
   localparam int POLICY_MSB = 7;
   localparam int POLICY_LSB = 6;
   localparam int TRIG_SEL_BIT = 5;
   localparam int COUNT_MSB = 4;
   localparam int TRIG_FLAG_BIT = 7;
   localparam logic [7:0] CTL_RESET = 8'h00;

   typedef enum logic [1:0] {
      POL_BYPASS = 2'h0,
      POL_FILL = 2'h1,
      POL_ROLL = 2'h2,
      POL_TRIG = 2'h3
   } policy_e;

   // gray along idle -> armed -> fired
   typedef enum logic [1:0] {
      TRG_IDLE = 2'h0,
      TRG_ARMED = 2'h1,
      TRG_FIRED = 2'h3
   } trig_state_e;

   typedef struct packed {
      logic [15:0] z;
      logic [15:0] y;
      logic [15:0] x;
   } sample_s;

   typedef struct packed {
      logic data_ready;
      logic watermark;
      logic overrun;
   } flags_s;
endpackage
`default_nettype wire

// ===== accel_host_model.sv
// host model on the register port
`default_nettype none
module accel_host_model (
   // clock and read data
   input wire logic sys_clk_in,
   input wire logic [7:0] reg_rdata_in,
   // register port
   output logic reg_wr_out = 1'b0,
   output logic reg_rd_out = 1'b0,
   output logic burst_end_out = 1'b0,
   output logic [5:0] reg_addr_out = 6'h00,
   output logic [7:0] reg_wdata_out = 8'h00
);
   timeunit 1ns;
   timeprecision 1ps;
   task automatic put(input logic w, input logic [5:0] a, input logic [7:0] d);
      @(negedge sys_clk_in);
      reg_wr_out = w;
      reg_rd_out = !w;
      reg_addr_out = a;
      reg_wdata_out = d;
      @(negedge sys_clk_in);
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
      reg_addr_out = ~a;
      reg_wdata_out = ~d;
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      put(1'b1, a, d);
   endtask
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      put(1'b0, a, 8'h00);
      d = reg_rdata_in;
   endtask
   // whole sample in one burst
   task automatic pop(output accel_fifo_pkg::sample_s s);
      logic [7:0] b;
      for (int i = 0; i < 6; i++) begin
         rd(6'h32 + 6'(i), b);
         s[i*8 +: 8] = b;
      end
      @(negedge sys_clk_in);
      burst_end_out = 1'b1;
      @(negedge sys_clk_in);
      burst_end_out = 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== accel_sample_fifo.sv
// sample queue with bypass, fill-and-stop, rolling and trigger policies
// Contract
// - policy bits D7:D6 choose four modes
// - fill-and-stop drops samples when 32 held
// - rolling keeps newest 32, overwriting oldest
// - trigger keeps pre-history then fills up
// - trigger select picks pin a or b
// - count zero sets watermark flag at once
// - count sets watermark level in fill/rolling
// - count sets pre-trigger history in trigger
// - status bit 7 shows trigger occurred
// - status reports stored entry count
// - first axis byte read of a burst pops entry
// - 32 stored plus one output sample
// - overrun set in fill/rolling, cleared by data read; other flags track the count
// - no writes into queue while asleep
`default_nettype none
module accel_sample_fifo (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   // sampler side
   input wire logic sample_valid_in,
   input wire accel_fifo_pkg::sample_s sample_in,
   input wire logic sleep_in,
   input wire logic event_pin_a_in,
   input wire logic event_pin_b_in,
   // register port
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic burst_end_in,
   input wire logic [5:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   // status flags
   output accel_fifo_pkg::flags_s flags_out
);
   accel_fifo_pkg::sample_s mem [accel_fifo_pkg::DEPTH];
   accel_fifo_pkg::sample_s out_hold, next_out_hold;
   logic out_valid, next_out_valid;
   logic [4:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
   logic [5:0] count, next_count;
   logic [7:0] ctl, next_ctl;
   logic [7:0] rdata, next_rdata;
   accel_fifo_pkg::flags_s flags, next_flags;
   accel_fifo_pkg::trig_state_e tstate, next_tstate;
   logic burst_open, next_burst_open;
   accel_fifo_pkg::sample_s shown, next_shown;
   logic do_write, do_pop, drop_oldest, trig_src;
   accel_fifo_pkg::policy_e policy;
   logic [4:0] samples;

   function automatic logic is_data_addr(input logic [5:0] a);
      is_data_addr = (a >= accel_fifo_pkg::REG_DATA_FIRST) && (a <= accel_fifo_pkg::REG_DATA_LAST);
   endfunction

   function automatic logic [7:0] pick_byte(input accel_fifo_pkg::sample_s s, input logic [5:0] a);
      logic [2:0] idx;
      idx = 3'(a - accel_fifo_pkg::REG_DATA_FIRST);
      pick_byte = s[idx*8 +: 8];
   endfunction

   assign policy = accel_fifo_pkg::policy_e'(ctl[accel_fifo_pkg::POLICY_MSB:accel_fifo_pkg::POLICY_LSB]);
   assign samples = ctl[accel_fifo_pkg::COUNT_MSB:0];
   assign trig_src = ctl[accel_fifo_pkg::TRIG_SEL_BIT] ? event_pin_b_in : event_pin_a_in;

   // ----------------------------------------------------------------
   // write / pop decisions
   // ----------------------------------------------------------------
   always_comb begin
      do_write = 1'b0;
      drop_oldest = 1'b0;
      if (sample_valid_in && !sleep_in) begin
         case (policy)
            accel_fifo_pkg::POL_BYPASS: do_write = 1'b0;
            accel_fifo_pkg::POL_FILL: do_write = (count != accel_fifo_pkg::DEPTH_CNT);
            accel_fifo_pkg::POL_ROLL: begin
               do_write = 1'b1;
               drop_oldest = (count == accel_fifo_pkg::DEPTH_CNT);
            end
            accel_fifo_pkg::POL_TRIG: begin
               if (tstate == accel_fifo_pkg::TRG_FIRED) begin
                  do_write = (count != accel_fifo_pkg::DEPTH_CNT);
               end else begin
                  // before the trigger only the last samples entries are kept
                  do_write = (samples != 5'h00);
                  drop_oldest = (count >= {1'b0, samples}) && (samples != 5'h00);
               end
            end
            default: do_write = 1'b0;
         endcase
      end
   end

   // pop once per burst on first data-byte read
   assign do_pop = reg_rd_in && is_data_addr(reg_addr_in) && !burst_open;

   // ----------------------------------------------------------------
   // queue storage and pointers
   // ----------------------------------------------------------------
   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count = count;
      next_out_hold = out_hold;
      next_out_valid = out_valid;
      if (do_write) begin
         next_wr_ptr = wr_ptr + 5'h01;
      end
      // output stage refills from queue head; a 33rd sample lives there
      if (do_pop || !out_valid) begin
         if (count != 6'h00) begin
            next_out_hold = mem[rd_ptr];
            next_out_valid = 1'b1;
            next_rd_ptr = rd_ptr + 5'h01;
            next_count = count - 6'h01;
         end else if (do_pop) begin
            next_out_valid = 1'b0;
         end
      end else if (drop_oldest) begin
         next_rd_ptr = rd_ptr + 5'h01;
         next_count = count - 6'h01;
      end
      if (do_write) begin
         next_count = next_count + 6'h01;
      end
      if (policy == accel_fifo_pkg::POL_BYPASS) begin
         next_count = 6'h00;
         next_rd_ptr = next_wr_ptr;
         next_out_valid = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (do_write) begin
         mem[wr_ptr] <= sample_in;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wr_ptr <= 5'h00;
         rd_ptr <= 5'h00;
         count <= 6'h00;
         out_hold <= '0;
         out_valid <= 1'b0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
         out_hold <= next_out_hold;
         out_valid <= next_out_valid;
      end
   end

   // ----------------------------------------------------------------
   // registers, trigger and flags
   // ----------------------------------------------------------------

   always_comb begin
      next_ctl = ctl;
      next_rdata = rdata;
      next_tstate = tstate;
      next_burst_open = burst_open;
      next_shown = shown;
      next_flags = flags;
      if (reg_wr_in && reg_addr_in == accel_fifo_pkg::REG_CTL) begin
         next_ctl = reg_wdata_in;
      end
      if (reg_rd_in) begin
         if (is_data_addr(reg_addr_in)) begin
            // later bytes of a burst come from the sample its first byte popped
            next_rdata = pick_byte(burst_open ? shown : out_hold, reg_addr_in);
            next_burst_open = 1'b1;
         end else if (reg_addr_in == accel_fifo_pkg::REG_CTL) begin
            next_rdata = ctl;
         end else if (reg_addr_in == accel_fifo_pkg::REG_STATUS) begin
            next_rdata = {tstate == accel_fifo_pkg::TRG_FIRED, 1'b0, count};
         end else begin
            next_rdata = 8'h00;
         end
      end
      if (burst_end_in) begin
         next_burst_open = 1'b0;
      end
      // trigger tracking
      if (policy != accel_fifo_pkg::POL_TRIG) begin
         next_tstate = accel_fifo_pkg::TRG_IDLE;
      end else begin
         case (tstate)
            accel_fifo_pkg::TRG_IDLE: next_tstate = accel_fifo_pkg::TRG_ARMED;
            accel_fifo_pkg::TRG_ARMED: begin
               if (trig_src) begin
                  next_tstate = accel_fifo_pkg::TRG_FIRED;
               end
            end
            accel_fifo_pkg::TRG_FIRED: next_tstate = accel_fifo_pkg::TRG_FIRED;
            default: next_tstate = accel_fifo_pkg::TRG_IDLE;
         endcase
      end
      // overrun clears on data read, but a same-cycle event wins
      if (do_pop) begin
         next_flags.overrun = 1'b0;
         next_shown = out_hold;
      end
      if ((sample_valid_in && !sleep_in && !do_write && policy == accel_fifo_pkg::POL_FILL)
          || (do_write && drop_oldest && policy == accel_fifo_pkg::POL_ROLL)) begin
         next_flags.overrun = 1'b1;
      end
      next_flags.watermark = (policy != accel_fifo_pkg::POL_BYPASS || samples == 5'h00)
         && (samples == 5'h00 || (next_count >= {1'b0, samples}));
      next_flags.data_ready = next_out_valid || (next_count != 6'h00);
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ctl <= accel_fifo_pkg::CTL_RESET;
         rdata <= 8'h00;
         tstate <= accel_fifo_pkg::TRG_IDLE;
         burst_open <= 1'b0;
         shown <= '0;
         flags <= '0;
      end else begin
         ctl <= next_ctl;
         rdata <= next_rdata;
         tstate <= next_tstate;
         burst_open <= next_burst_open;
         shown <= next_shown;
         flags <= next_flags;
      end
   end

   assign reg_rdata_out = rdata;
   assign flags_out = flags;
endmodule
`default_nettype wire

// ===== accel_sample_fifo_assertions.sv
// port checker of the sample queue
`default_nettype none
module accel_sample_fifo_assertions (
   // watched ports
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [5:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic [7:0] reg_rdata_out,
   input wire accel_fifo_pkg::flags_s flags_out
);
   logic [7:0] ctl;
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) ctl <= 8'h00;
      else if (reg_wr_in && reg_addr_in == 6'h38) ctl <= reg_wdata_in;
   end
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);
   sequence s_stat;
      reg_rd_in && reg_addr_in == 6'h39;
   endsequence
   sequence s_zero;
      reg_wr_in && reg_addr_in == 6'h38 && reg_wdata_in[4:0] == 5'h00 && reg_wdata_in[7:6] != 2'h3;
   endsequence
   a_rdata_holds: assert property (!reg_rd_in |=> $stable(reg_rdata_out)) else $error("read data moved");
   a_unmapped_zero: assert property (reg_rd_in && reg_addr_in == 6'h00 |=> reg_rdata_out == 8'h00) else $error("unmapped");
   a_count_max: assert property (s_stat |=> reg_rdata_out[5:0] <= 6'h20) else $error("count high");
   a_status_gap: assert property (s_stat |=> !reg_rdata_out[6]) else $error("status bit 6");
   a_bypass_empty: assert property (s_stat and (ctl[7:6] == 2'h0 && $past(ctl[7:6]) == 2'h0)
      |=> reg_rdata_out[5:0] == 6'h00) else $error("bypass count");
   a_trig_clear: assert property (s_stat and (ctl[7:6] != 2'h3 && $past(ctl[7:6]) != 2'h3)
      |=> !reg_rdata_out[7]) else $error("trigger flag");
   a_zero_mark: assert property (s_zero |=> ##[0:1] flags_out.watermark) else $error("zero count");
   a_ctl_back: assert property (reg_rd_in && !reg_wr_in && reg_addr_in == 6'h38 |=> reg_rdata_out == ctl)
      else $error("control readback");
endmodule
bind accel_sample_fifo accel_sample_fifo_assertions accel_sample_fifo_assertions_i (.sys_clk_in(sys_clk_in),
   .rst_b_in(rst_b_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .flags_out(flags_out));
`default_nettype wire

// ===== accel_sample_fifo_tb_top.sv
// self-checking bench of the sample queue
`default_nettype none
module accel_sample_fifo_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic vld = 1'b0;
   accel_fifo_pkg::sample_s smp = '0;
   logic slp = 1'b0;
   logic pa = 1'b0;
   logic pb = 1'b0;
   logic wr, rd, be;
   logic [5:0] ad;
   logic [7:0] wd, rdat, b;
   accel_fifo_pkg::sample_s got;
   accel_fifo_pkg::flags_s fl;
   int failures = 0;
   int checks = 0;
   int cyc = 0;
   initial forever #5 sys_clk_in = ~sys_clk_in;
   accel_sample_fifo accel_sample_fifo_i (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .sample_valid_in(vld),
      .sample_in(smp), .sleep_in(slp), .event_pin_a_in(pa), .event_pin_b_in(pb), .reg_wr_in(wr),
      .reg_rd_in(rd), .burst_end_in(be), .reg_addr_in(ad), .reg_wdata_in(wd), .reg_rdata_out(rdat),
      .flags_out(fl));
   accel_host_model accel_host_model_i (.sys_clk_in(sys_clk_in), .reg_rdata_in(rdat), .reg_wr_out(wr),
      .reg_rd_out(rd), .burst_end_out(be), .reg_addr_out(ad), .reg_wdata_out(wd));
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic push(input int n);
      repeat (n) begin
         @(negedge sys_clk_in);
         vld = 1'b1;
         smp.x = smp.x + 16'h0001;
         smp.z = {smp.x[7:0], smp.x[15:8]};
         @(negedge sys_clk_in);
         vld = 1'b0;
      end
   endtask
   task automatic st();
      accel_host_model_i.rd(6'h39, b);
   endtask
   task automatic mode(input logic [7:0] c);
      accel_host_model_i.wr(6'h38, 8'h00);
      accel_host_model_i.wr(6'h38, c);
   endtask
   task automatic pulse(input logic s);
      @(negedge sys_clk_in);
      pa = !s;
      pb = s;
      @(negedge sys_clk_in);
      pa = 1'b0;
      pb = 1'b0;
   endtask
   task automatic t_fill();
      mode(8'h5F);
      push(40);
      st();
      chk(b, 8'h20);
      chk(8'(fl), 8'h07);
      accel_host_model_i.pop(got);
      chk(got.x[7:0], 8'h04);
      chk(got.z[15:8], 8'h04);
      st();
      chk(b, 8'h1F);
      chk(8'(fl), 8'h06);
      accel_host_model_i.pop(got);
      chk(got.x[7:0], 8'h05);
      chk(8'(fl), 8'h04);
      push(3);
      st();
      chk(b, 8'h20);
      $display("test fill done");
   endtask
   task automatic t_roll();
      mode(8'h84);
      push(40);
      st();
      chk(b, 8'h20);
      chk(8'(fl), 8'h07);
      slp = 1'b1;
      accel_host_model_i.pop(got);
      push(3);
      st();
      chk(b, 8'h1F);
      slp = 1'b0;
      $display("test roll done");
   endtask
   task automatic t_misc();
      accel_host_model_i.rd(6'h00, b);
      chk(b, 8'h00);
      mode(8'h00);
      push(3);
      st();
      chk(b, 8'h00);
      mode(8'h40);
      chk(8'(fl.watermark), 8'h01);
      mode(8'h80);
      chk(8'(fl.watermark), 8'h01);
      accel_host_model_i.rd(6'h38, b);
      chk(b, 8'h80);
      $display("test misc done");
   endtask
   task automatic t_trig(input logic s);
      mode({2'h3, s, 5'h04});
      push(10);
      st();
      chk(b, 8'h04);
      pulse(!s);
      st();
      chk(b, 8'h04);
      pulse(s);
      push(40);
      st();
      chk(b, 8'hA0);
      $display("test trigger done");
   endtask
   task automatic print_verdict();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge sys_clk_in) begin
      cyc++;
      if (cyc == 6000) begin
         failures++;
         print_verdict();
      end
   end
   initial begin
      repeat (5) @(negedge sys_clk_in);
      rst_b_in = 1'b1;
      t_misc();
      t_fill();
      t_roll();
      t_trig(1'b0);
      t_trig(1'b1);
      print_verdict();
   end
endmodule
`default_nettype wire
